// >>> hw/dss_sram_end.sv
// Purpose: SRAM end of a split-port DDR link with one shared address bus.
// Assumes: Link pins are driven by logic on core_clk; clock pins are levels.
// Notes: A link clock rise is seen in the core cycle where the pin goes high.
// The array has no reset, and a read taken with a write to the same address
// returns the new word, since the write lands at K# before the read fetches.
//
// Functional notes
// - Write data taken on both input clock rises.
// - Low write select at K rise starts write.
// - High write select: data ignored, no write.
// - 8-bit: nibble enables gate bits 3:0, 7:4.
// - Byte enables gate ascending 9-bit groups.
// - Lane enables sampled with their data beat.
// - Each beat carries its own lane enables.
// - Read address at K rise, write at K#.
// - Two array halves, one per burst beat.
// - Address ignored when its port is idle.
// - Read beats on output clock rises or K.
// - Deselected read port floats its data outputs.
// - Read: two words; tristate after next C rise.
// - Every access starts on a K rise.
`timescale 1ns/1ps
`include "dss_link_regs.svh"

module dss_sram_end #(
  parameter int DATA_W = `DSS_DATA_W_DEF,
  parameter int ADDR_W = `DSS_ADDR_W_DEF,
  parameter int LANE_W = (DATA_W == `DSS_NIBBLE_DATA_W) ? `DSS_NIBBLE_W : `DSS_BYTE_W,
  parameter int LANES = DATA_W / LANE_W
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // synchronous reset, active high
  dss_link_if.sram link, // pins from the controller
  output logic wrDone, // pulse: a burst was stored
  output logic rdStarted // pulse: a read was accepted
);
  import dss_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ========================================================================
  // State
  typedef struct packed {
    logic kPrev;
    logic kNPrev;
    logic oPrev;
    logic oNPrev;
    logic wrPending;
    logic [DATA_W-1:0] wrBeat0;
    logic [LANES-1:0] wrMask0;
    logic rdPending;
    logic [ADDR_W-1:0] rdAddr;
    logic [ADDR_W-1:0] outAddr;
    logic beat1Due;
    logic [DATA_W-1:0] q;
    logic qOe;
    logic wrDone;
    logic rdStarted;
  } dss_sram_state_type;

  dss_sram_state_type st_ff;
  dss_sram_state_type nxt_st;

  // ========================================================================
  // Array
  // Contents survive reset; a word that was never written reads as unknown.
  // Each half holds one beat of every burst, so one address picks both.
  logic [DATA_W-1:0] memLow [0:DEPTH-1];
  logic [DATA_W-1:0] memHigh [0:DEPTH-1];

  logic kRise;
  logic kNRise;
  logic outPos;
  logic outNeg;
  logic oRise;
  logic oNRise;
  logic wrFire;
  logic [DATA_W-1:0] oldLow;
  logic [DATA_W-1:0] oldHigh;
  logic [DATA_W-1:0] newLow;
  logic [DATA_W-1:0] newHigh;

  // ========================================================================
  // Edge detection
  // The link clocks are levels launched on core_clk, so a rise is simply the
  // first cycle in which the pin reads high; no synchroniser is needed.
  assign kRise = link.kClk & ~st_ff.kPrev;
  assign kNRise = link.kClkN & ~st_ff.kNPrev;
  // Single clock mode takes the output beats from the input clock pair.
  assign outPos = link.singleClk ? link.kClk : link.cClk;
  assign outNeg = link.singleClk ? link.kClkN : link.cClkN;
  assign oRise = outPos & ~st_ff.oPrev;
  assign oNRise = outNeg & ~st_ff.oNPrev;

  // ========================================================================
  // Write merge
  // The write address is only looked at when the second beat lands.
  assign wrFire = kNRise & st_ff.wrPending;
  assign oldLow = memLow[link.addr];
  assign oldHigh = memHigh[link.addr];

  // Beat 0 waits in the state word until beat 1 and the address arrive.
  dss_lane_merge #(
    .DATA_W(DATA_W),
    .LANE_W(LANE_W),
    .LANES(LANES)
  ) u_dss_lane_merge_low (
    .oldWord(oldLow),
    .newWord(st_ff.wrBeat0),
    .laneEnN(st_ff.wrMask0),
    .mergedWord(newLow)
  );

  // Beat 1 is merged straight from the pins in the cycle in which it arrives.
  dss_lane_merge #(
    .DATA_W(DATA_W),
    .LANE_W(LANE_W),
    .LANES(LANES)
  ) u_dss_lane_merge_high (
    .oldWord(oldHigh),
    .newWord(link.wrData),
    .laneEnN(link.byteLaneWriteEnN),
    .mergedWord(newHigh)
  );

  // ========================================================================
  // Array write
  // Both halves are written in one cycle, so a burst never lands half done.
  always_ff @(posedge core_clk) begin
    if (wrFire) begin
      memLow[link.addr] <= newLow;
      memHigh[link.addr] <= newHigh;
    end
  end

  // ========================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.kPrev = link.kClk;
    nxt_st.kNPrev = link.kClkN;
    nxt_st.oPrev = outPos;
    nxt_st.oNPrev = outNeg;
    nxt_st.wrDone = 1'b0;
    nxt_st.rdStarted = 1'b0;

    // Write port: select and first beat at K, second beat and address at K#.
    if (kRise) begin
      nxt_st.wrPending = ~link.writePortSelN;
      if (!link.writePortSelN) begin
        nxt_st.wrBeat0 = link.wrData;
        nxt_st.wrMask0 = link.byteLaneWriteEnN;
      end
    end else if (kNRise) begin
      nxt_st.wrPending = 1'b0;
      nxt_st.wrDone = st_ff.wrPending;
    end

    // Output side: a C rise consumes the read taken at an earlier K rise.
    // The C rise that coincides with the read's own K rise still sees the old
    // pending flag, so beat 0 leaves one input clock period later.
    if (oRise) begin
      nxt_st.rdPending = 1'b0;
      if (st_ff.rdPending) begin
        nxt_st.q = memLow[st_ff.rdAddr];
        nxt_st.qOe = 1'b1;
        nxt_st.outAddr = st_ff.rdAddr;
        nxt_st.beat1Due = 1'b1;
      end else begin
        // The last beat of a read stands until this edge, then floats.
        nxt_st.qOe = 1'b0;
        nxt_st.beat1Due = 1'b0;
      end
    end else if (oNRise && st_ff.beat1Due) begin
      nxt_st.q = memHigh[st_ff.outAddr];
      nxt_st.beat1Due = 1'b0;
    end

    // Read port works alone; a write in the same period never holds it up.
    if (kRise) begin
      nxt_st.rdPending = ~link.readPortSelN;
      nxt_st.rdStarted = ~link.readPortSelN;
      if (!link.readPortSelN) begin
        nxt_st.rdAddr = link.addr;
      end
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // The negative-phase pins idle high, so their detectors start high too;
      // starting them low would report a false K# rise at release.
      st_ff <= '0;
      st_ff.kNPrev <= 1'b1;
      st_ff.oNPrev <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // Outputs
  // Every pin and pulse comes straight from the state register.
  assign link.rdData = st_ff.q;
  assign link.rdDataOe = st_ff.qOe;
  assign wrDone = st_ff.wrDone;
  assign rdStarted = st_ff.rdStarted;

endmodule // dss_sram_end

// >>> include/dss_link_regs.svh
// Purpose: Shared constants for the split-port double data rate SRAM link.
// Assumes: Included by bare name from the package, interface and both end modules.
// Notes: Widths default to the 18-bit variant with its 19 address bits.
`ifndef DSS_LINK_REGS_SVH
`define DSS_LINK_REGS_SVH

// ==========================================================================
// Variant widths
`define DSS_DATA_W_DEF 18
`define DSS_ADDR_W_DEF 19
`define DSS_NIBBLE_DATA_W 8
`define DSS_NIBBLE_W 4
`define DSS_BYTE_W 9

// ==========================================================================
// Link timing: core clock cycles per input clock period
`define DSS_PHASES 4

// ==========================================================================
// Reset values of the pins
`define DSS_SEL_IDLE 1'b1
`define DSS_SINGLE_CLK_DEF 1'b0

`endif

// >>> include/dss_pkg.sv
// Purpose: Types shared by both ends of the SRAM link.
// Assumes: Constants come from dss_link_regs.svh.
// Notes: The phase enum names the four core cycles of one input clock period.
`include "dss_link_regs.svh"

package dss_pkg;

  // ========================================================================
  // Input clock phase
  typedef enum logic [1:0] {
    PH_K_RISE = 2'b00,
    PH_K_HIGH = 2'b01,
    PH_KN_RISE = 2'b10,
    PH_KN_HIGH = 2'b11
  } dss_phase_type;

endpackage : dss_pkg

// >>> include/dss_link_if.sv
// Purpose: Pin bundle between the memory controller and the SRAM.
// Assumes: Both ends run on the same core clock; link clocks are plain levels.
// Notes: The read data bus is three-state, carried as data plus an enable that only the checker watches.
`timescale 1ns/1ps
`include "dss_link_regs.svh"

interface dss_link_if #(
  parameter int DATA_W = `DSS_DATA_W_DEF,
  parameter int ADDR_W = `DSS_ADDR_W_DEF,
  parameter int LANES = 2
);
  logic kClk;
  logic kClkN;
  logic cClk;
  logic cClkN;
  logic singleClk;
  logic writePortSelN;
  logic readPortSelN;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData;
  logic [LANES-1:0] byteLaneWriteEnN;
  logic [DATA_W-1:0] rdData;
  logic rdDataOe;

  modport ctrl (
    output kClk, kClkN, cClk, cClkN, singleClk, writePortSelN, readPortSelN,
    output addr, wrData, byteLaneWriteEnN,
    input rdData, rdDataOe
  );

  modport sram (
    input kClk, kClkN, cClk, cClkN, singleClk, writePortSelN, readPortSelN,
    input addr, wrData, byteLaneWriteEnN,
    output rdData, rdDataOe
  );
endinterface : dss_link_if

// >>> hw/dss_lane_merge.sv
// Purpose: Merge one write beat into a stored word, lane by lane.
// Assumes: Lane enables are active low, lane 0 covers the lowest bits.
// Notes: Used once per burst beat by the SRAM end.
`timescale 1ns/1ps

module dss_lane_merge #(
  parameter int DATA_W = 18,
  parameter int LANE_W = 9,
  parameter int LANES = 2
) (
  input wire logic [DATA_W-1:0] oldWord, // word now in the array
  input wire logic [DATA_W-1:0] newWord, // beat from the write pins
  input wire logic [LANES-1:0] laneEnN, // per-lane write enables
  output logic [DATA_W-1:0] mergedWord // word to store
);
  import dss_pkg::*;

  // ========================================================================
  // Lane select
  for (genvar i = 0; i < LANES; i++) begin : gLane
    assign mergedWord[i*LANE_W +: LANE_W] = laneEnN[i] ?
        oldWord[i*LANE_W +: LANE_W] : newWord[i*LANE_W +: LANE_W];
  end

endmodule // dss_lane_merge

// >>> hw/dss_ctrl_end.sv
// Purpose: Controller end: turns user requests into link cycles.
// Assumes: The SRAM end runs on the same core_clk.
// Notes: One input clock period spans four core cycles; C and C# follow K and K#.
`timescale 1ns/1ps
`include "dss_link_regs.svh"

module dss_ctrl_end #(
  parameter int DATA_W = `DSS_DATA_W_DEF,
  parameter int ADDR_W = `DSS_ADDR_W_DEF,
  parameter int LANES = 2,
  parameter bit SINGLE_CLK = `DSS_SINGLE_CLK_DEF
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // synchronous reset, active high
  dss_link_if.ctrl link, // pins to the SRAM
  input wire logic wrReq, // write request, level
  input wire logic [ADDR_W-1:0] wrAddr, // write address
  input wire logic [2*DATA_W-1:0] wrData, // beat 1 high, beat 0 low
  input wire logic [2*LANES-1:0] wrLaneEnN, // lane enables per beat
  output logic wrTaken, // pulse: write accepted
  input wire logic rdReq, // read request, level
  input wire logic [ADDR_W-1:0] rdAddr, // read address
  output logic rdTaken, // pulse: read accepted
  output logic rdValid, // pulse: rdBurst holds a burst
  output logic [2*DATA_W-1:0] rdBurst // beat 1 high, beat 0 low
);
  import dss_pkg::*;

  typedef struct packed {
    dss_phase_type phase;
    logic kClk;
    logic kClkN;
    logic singleClk;
    logic wrSelN;
    logic rdSelN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dOut;
    logic [LANES-1:0] maskN;
    logic wrArmed;
    logic [ADDR_W-1:0] wrAddrHold;
    logic [DATA_W-1:0] beat1Hold;
    logic [LANES-1:0] mask1Hold;
    logic [2:0] rdPipe;
    logic [DATA_W-1:0] rdBeat0;
    logic [2*DATA_W-1:0] rdBurst;
    logic rdValid;
    logic wrTaken;
    logic rdTaken;
  } dss_ctrl_state_type;

  dss_ctrl_state_type st_ff;
  dss_ctrl_state_type nxt_st;

  // ========================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wrTaken = 1'b0;
    nxt_st.rdTaken = 1'b0;
    nxt_st.rdValid = 1'b0;
    unique case (st_ff.phase)
      PH_KN_HIGH: begin
        // Every access is issued so that it is seen at the K rise.
        nxt_st.phase = PH_K_RISE;
        nxt_st.kClk = 1'b1;
        nxt_st.kClkN = 1'b0;
        nxt_st.wrSelN = ~wrReq;
        nxt_st.rdSelN = ~rdReq;
        nxt_st.wrArmed = wrReq;
        nxt_st.wrTaken = wrReq;
        nxt_st.rdTaken = rdReq;
        if (rdReq) begin
          nxt_st.addr = rdAddr;
        end
        nxt_st.dOut = wrData[DATA_W-1:0];
        nxt_st.maskN = wrLaneEnN[LANES-1:0];
        nxt_st.wrAddrHold = wrAddr;
        nxt_st.beat1Hold = wrData[2*DATA_W-1:DATA_W];
        nxt_st.mask1Hold = wrLaneEnN[2*LANES-1:LANES];
        nxt_st.rdPipe = {st_ff.rdPipe[1:0], rdReq};
      end
      PH_K_RISE: begin
        nxt_st.phase = PH_K_HIGH;
        if (st_ff.rdPipe[2]) begin
          nxt_st.rdBurst = {link.rdData, st_ff.rdBeat0};
          nxt_st.rdValid = 1'b1;
        end
      end
      PH_K_HIGH: begin
        nxt_st.phase = PH_KN_RISE;
        nxt_st.kClk = 1'b0;
        nxt_st.kClkN = 1'b1;
        nxt_st.wrSelN = `DSS_SEL_IDLE;
        nxt_st.rdSelN = `DSS_SEL_IDLE;
        nxt_st.dOut = st_ff.beat1Hold;
        nxt_st.maskN = st_ff.mask1Hold;
        if (st_ff.wrArmed) begin
          nxt_st.addr = st_ff.wrAddrHold;
        end
      end
      PH_KN_RISE: begin
        nxt_st.phase = PH_KN_HIGH;
        if (st_ff.rdPipe[1]) begin
          nxt_st.rdBeat0 = link.rdData;
        end
      end
    endcase
  end

  // ========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.phase <= PH_KN_HIGH;
      st_ff.kClkN <= 1'b1;
      st_ff.singleClk <= SINGLE_CLK;
      st_ff.wrSelN <= `DSS_SEL_IDLE;
      st_ff.rdSelN <= `DSS_SEL_IDLE;
      st_ff.maskN <= '1;
      st_ff.mask1Hold <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.kClk = st_ff.kClk;
  assign link.kClkN = st_ff.kClkN;
  assign link.cClk = st_ff.kClk;
  assign link.cClkN = st_ff.kClkN;
  assign link.singleClk = st_ff.singleClk;
  assign link.writePortSelN = st_ff.wrSelN;
  assign link.readPortSelN = st_ff.rdSelN;
  assign link.addr = st_ff.addr;
  assign link.wrData = st_ff.dOut;
  assign link.byteLaneWriteEnN = st_ff.maskN;
  assign wrTaken = st_ff.wrTaken;
  assign rdTaken = st_ff.rdTaken;
  assign rdValid = st_ff.rdValid;
  assign rdBurst = st_ff.rdBurst;

endmodule // dss_ctrl_end

// >>> tb/dss_link_chk.sv
// Purpose: Pin-level checks on the link between the two ends.
// Assumes: Every link pin is a flop output on core_clk.
// Notes: Read data timing follows the four-cycle K period of the pair.
`timescale 1ns/1ps

module dss_link_chk #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 19,
  parameter int LANES = 2
) (
  input wire logic core_clk, // core clock
  input wire logic reset, // sync reset, high
  input wire logic kClk, // K
  input wire logic kClkN, // K#
  input wire logic cClk, // C
  input wire logic cClkN, // C#
  input wire logic singleClk, // read beats on K
  input wire logic writePortSelN, // write select
  input wire logic readPortSelN, // read select
  input wire logic [ADDR_W-1:0] addr, // shared address
  input wire logic [DATA_W-1:0] wrData, // write beats
  input wire logic [LANES-1:0] byteLaneWriteEnN, // lane enables
  input wire logic [DATA_W-1:0] rdData, // read beats
  input wire logic rdDataOe // read drive enable
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ==========================================================================
  // Clocks and selects
  clk_pair_a: assert property (kClkN == !kClk)
    else $error("K and K# not complementary");
  k_period_a: assert property ($rose(kClk) |=> kClk ##1 !kClk [*2] ##1 kClk)
    else $error("K period is not four cycles");
  wsel_k_a: assert property (!writePortSelN |-> kClk)
    else $error("write select away from K high");
  rsel_k_a: assert property ($fell(readPortSelN) |-> $rose(kClk))
    else $error("read select not at K rise");
  out_clk_a: assert property (!singleClk |-> cClk == kClk && cClkN == kClkN)
    else $error("C pair not following K pair");

  // ==========================================================================
  // Read data drive
  rd_drive_a: assert property ($rose(kClk) && !readPortSelN |-> ##5 rdDataOe [*4])
    else $error("read beats not driven");
  rd_float_a: assert property ($rose(kClk) && readPortSelN |-> ##5 !rdDataOe)
    else $error("read data driven while idle");
  oe_cause_a: assert property ($rose(rdDataOe) |->
    $past(readPortSelN, 5) == 1'b0 && $past(kClk, 5))
    else $error("read drive without a read");

  cover property ($rose(kClk) && !writePortSelN && !readPortSelN);
  cover property ($rose(kClk) && !writePortSelN && byteLaneWriteEnN != '1);
  cover property ($rose(rdDataOe));
endmodule // dss_link_chk

// >>> tb/tb_ddr_split_port_sram_io.sv
// Purpose: Self-checking bench for the controller and SRAM ends together.
// Assumes: 18-bit variant, two 9-bit lanes per beat.
// Notes: Reads never target an address with a write in flight.
`timescale 1ns/1ps

module tb_ddr_split_port_sram_io;
  import dss_pkg::*;
  logic core_clk, reset, wrReq, rdReq, wrTaken, rdTaken, rdValid, wrDone, rdStarted;
  logic [18:0] wrAddr, rdAddr;
  logic [35:0] wrData, rdBurst, e1;
  logic [3:0] wrLaneEnN;
  int n_mismatch, n_checks;

  dss_link_if link();
  dss_sram_end u_dss_sram_end (.core_clk(core_clk), .reset(reset), .link(link),
    .wrDone(wrDone), .rdStarted(rdStarted));
  dss_ctrl_end u_dss_ctrl_end (.core_clk(core_clk), .reset(reset), .link(link),
    .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData), .wrLaneEnN(wrLaneEnN),
    .wrTaken(wrTaken), .rdReq(rdReq), .rdAddr(rdAddr), .rdTaken(rdTaken),
    .rdValid(rdValid), .rdBurst(rdBurst));
  dss_link_chk u_dss_link_chk (.core_clk(core_clk), .reset(reset), .kClk(link.kClk),
    .kClkN(link.kClkN), .cClk(link.cClk), .cClkN(link.cClkN), .singleClk(link.singleClk),
    .writePortSelN(link.writePortSelN), .readPortSelN(link.readPortSelN),
    .addr(link.addr), .wrData(link.wrData), .byteLaneWriteEnN(link.byteLaneWriteEnN),
    .rdData(link.rdData), .rdDataOe(link.rdDataOe));

  always #12.5 core_clk = ~core_clk;

  // ==========================================================================
  // Shared tasks
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? wrTaken : (w == 1) ? rdTaken : rdValid;
  endfunction

  // A handshake that never comes ends the run rather than hanging it.
  task automatic waitFor(input int w);
    for (int i = 0; i < 20 && pick(w) !== 1'b1; i++) begin
      tick();
    end
    if (pick(w) !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [18:0] a, input logic [35:0] d, input logic [3:0] m);
    wrReq = 1'b1;
    wrAddr = a;
    wrData = d;
    wrLaneEnN = m;
    waitFor(0);
    wrReq = 1'b0;
    rdReq = 1'b0;
    chk(36'h0, 36'(link.writePortSelN));
    chk(36'(d[17:0]), 36'(link.wrData));
    chk(36'(m[1:0]), 36'(link.byteLaneWriteEnN));
    tick();
    tick();
    chk(36'(a), 36'(link.addr));
    chk(36'(d[35:18]), 36'(link.wrData));
    chk(36'(m[3:2]), 36'(link.byteLaneWriteEnN));
    tick();
    if (m != 4'hF) begin
      chk(36'h1, 36'(wrDone));
    end
  endtask

  task automatic rd(input logic [18:0] a, input logic [35:0] e);
    rdReq = 1'b1;
    rdAddr = a;
    waitFor(1);
    rdReq = 1'b0;
    chk(36'(a), 36'(link.addr));
    chk(36'h0, 36'(link.readPortSelN));
    tick();
    chk(36'h1, 36'(rdStarted));
    waitFor(2);
    chk(e, rdBurst);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic sc_basic();
    wr(19'h00000, 36'h123456789, 4'h0);
    wr(19'h7FFFF, 36'hFEDCBA987, 4'h0);
    rd(19'h00000, 36'h123456789);
    rd(19'h7FFFF, 36'hFEDCBA987);
  endtask

  task automatic sc_lanes();
    e1 = {9'h02_4, 18'h2AAAA, 9'h189};
    e1[35:27] = 9'(36'h123456789 >> 27);
    wr(19'h00000, 36'h555555555, 4'b1001);
    wr(19'h00000, 36'h000000000, 4'hF);
    // Idle periods now carry this pattern with the write select high.
    wrData = 36'hFFFFFFFFF;
    wrLaneEnN = 4'h0;
    rd(19'h00000, e1);
    wr(19'h00000, 36'h000000000, 4'b0110);
    rd(19'h00000, {9'h000, e1[26:9], 9'h000});
  endtask

  // A read and a write taken on the same K rise must both finish.
  task automatic sc_concurrent();
    rdReq = 1'b1;
    rdAddr = 19'h7FFFF;
    wr(19'h12345, 36'h3C3C3C3C3, 4'h0);
    waitFor(2);
    chk(36'hFEDCBA987, rdBurst);
    rd(19'h12345, 36'h3C3C3C3C3);
  endtask

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    wrReq = 1'b0;
    rdReq = 1'b0;
    wrAddr = 19'h0;
    rdAddr = 19'h0;
    wrData = 36'h0;
    wrLaneEnN = 4'hF;
    n_mismatch = 0;
    n_checks = 0;
    repeat (3) tick();
    reset = 1'b0;
    sc_basic();
    sc_lanes();
    sc_concurrent();
    end_sim();
  end
endmodule // tb_ddr_split_port_sram_io
